// ### hdl/mlic_pkg.sv
// What this block does
// R1: Reset address is zero with fuse set, else boot address; vectors follow table select.
// R2: Control bit 6 puts vectors at application start when 0, boot start when 1.
// R3: Status bit 7 is set while a non-maskable handler runs, cleared by its return.
// R4: Status bit 2 set while high handler runs, even under a non-maskable one.
// R5: Status bit 1 set while medium handler runs, even when preempted.
// R6: Status bit 0 set while low handler runs, even when preempted.
// R7: With rotation on, the pointer records the last acknowledged low vector, then ranked lowest.
// R8: Software may read and write the pointer at any time, changing the low ranking; a write in the same cycle as a recorded low take (rotation on) is dropped.
// R9: Turning rotation off keeps the pointer; writing zero restores static order.
// R10: Control bit 7 turns on rotating arbitration among low requests.
// R11: With control bit 7 clear, the lowest low vector wins.
// R12: Table select changes only while the protection unlock window is open.
// R13: Control bit 2 enables high requests; otherwise they are never acknowledged.
// R14: Control bit 1 enables medium requests; otherwise they are never acknowledged.
// R15: Control bit 0 enables low requests; otherwise they are never acknowledged.
// R16: A cleared level enable masks requests from the next cycle on.
// R17: Each request carries a level: 00 off, 01 low, 10 medium, 11 high.
// R18: A higher level preempts a lower handler, which resumes after the higher returns.
// R19: Nothing preempts a non-maskable handler; among them the lowest vector wins.
// R20: High, medium and non-maskable use static order; only low may rotate.
// R21: Reserved status and control bits read zero and ignore writes.
// R22: Each return clears only the flag of the highest running level.
package mlic_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [1:0] ADDR_STATUS = 2'h0;
	localparam logic [1:0] ADDR_PTR = 2'h1;
	localparam logic [1:0] ADDR_CTRL = 2'h2;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int STATUS_NMI_BIT = 7;
	localparam int CTRL_ROT_BIT = 7;
	localparam int CTRL_SEL_BIT = 6;
	localparam int LVL_HI_BIT = 2;
	localparam int LVL_MED_BIT = 1;
	localparam int LVL_LO_BIT = 0;

	// ----------------------------------------
	// Vector placement
	// ----------------------------------------
	localparam logic [15:0] RESET_APP_ADDR = 16'h0000;
	localparam logic [15:0] VEC_STRIDE = 16'h0002;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		LVL_OFF = 2'b00,
		LVL_LO = 2'b01,
		LVL_MED = 2'b10,
		LVL_HI = 2'b11
	} lvl_t;

	typedef struct packed
	{
		logic valid;
		logic nmi;
		lvl_t level;
		logic [7:0] vector;
	} offer_t;

	typedef struct packed
	{
		logic rot_en;
		logic vec_sel;
		logic hi_en;
		logic med_en;
		logic lo_en;
	} ctrl_t;

	typedef struct packed
	{
		logic nmi;
		logic hi;
		logic med;
		logic lo;
	} run_t;

endpackage

// ### hdl/level_sync.sv
`timescale 1ns/100ps
`default_nettype none
module level_sync
	import mlic_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	initial
	begin
		if (WIDTH < 1)
			$error("level_sync needs WIDTH of at least one");
	end

	// Second stage alone feeds logic
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;

endmodule
`default_nettype wire

// ### hdl/lowest_first_pick.sv
`timescale 1ns/100ps
`default_nettype none
module lowest_first_pick
	import mlic_pkg::*;
#(
	parameter int WIDTH = 32
)
(
	input wire logic [WIDTH-1:0] req_i,
	input wire logic [7:0] start_i,
	output logic hit_o,
	output logic [7:0] index_o
);

	initial
	begin
		if (WIDTH < 1 || WIDTH > 255)
			$error("lowest_first_pick WIDTH must be 1 to 255");
	end

	// Lowest set index at or above floor; bit 8 tells found
	function automatic logic [8:0] first_from(input logic [WIDTH-1:0] req, input logic [7:0] floor);
		logic [8:0] res;
		res = 9'h000;
		for (int i = WIDTH - 1; i >= 0; i--)
		begin
			if (req[i] && i >= int'(floor))
				res = {1'b1, 8'(i)};
		end
		return res;
	endfunction

	logic [8:0] upper;
	logic [8:0] any;

	// Wraps to the bottom when nothing sits at or above the start
	always_comb
	begin
		upper = first_from(req_i, start_i);
		any = first_from(req_i, 8'h00);
		hit_o = any[8];
		index_o = upper[8] ? upper[7:0] : any[7:0];
	end

endmodule
`default_nettype wire

// ### hdl/multilevel_interrupt_unit.sv
`timescale 1ns/100ps
`default_nettype none
module multilevel_interrupt_unit
	import mlic_pkg::*;
#(
	parameter int NSRC = 32,
	parameter logic [15:0] BOOT_ADDR = 16'h1000
)
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic ccp_unlock_i,
	input wire logic boot_reset_fuse_i,
	input wire logic [2*NSRC-1:0] req_level_i,
	input wire logic [NSRC-1:0] nmi_req_i,
	input wire logic take_i,
	input wire logic return_from_interrupt_i,
	output offer_t irq_offer_o,
	output logic [15:0] irq_addr_o,
	output logic [15:0] reset_addr_o
);

	initial
	begin
		if (NSRC < 1 || NSRC > 254)
			$error("NSRC must be 1 to 254");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	ctrl_t ctrl_ff;
	run_t run_ff;
	run_t nxt_run;
	logic [7:0] ptr_ff;
	logic [7:0] nxt_ptr;
	offer_t offer_ff;
	offer_t nxt_offer;
	logic [15:0] addr_ff;
	logic [15:0] reset_addr_ff;
	logic [7:0] rdata_ff;
	logic fuse_sync;
	logic [1:0] settle_ff;

	logic [NSRC-1:0] hi_mask;
	logic [NSRC-1:0] med_mask;
	logic [NSRC-1:0] lo_mask;
	logic nmi_hit;
	logic hi_hit;
	logic med_hit;
	logic lo_hit;
	logic [7:0] nmi_idx;
	logic [7:0] hi_idx;
	logic [7:0] med_idx;
	logic [7:0] lo_idx;
	logic [7:0] lo_start;
	logic wr_ptr;
	logic wr_ctrl;
	logic take_low;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	// ----------------------------------------
	// Strap and reset vector
	// ----------------------------------------
	level_sync #(.WIDTH(1)) u_fuse_sync
	(
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(boot_reset_fuse_i),
		.sync_o(fuse_sync)
	);

	// Synchroniser shows its reset level for two edges; no false boot address
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			settle_ff <= 2'h0;
		else
			settle_ff <= {settle_ff[0], 1'b1};
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			reset_addr_ff <= RESET_APP_ADDR;
		else
			reset_addr_ff <= (fuse_sync || !settle_ff[1]) ? RESET_APP_ADDR : BOOT_ADDR; // R1
	end

	// ----------------------------------------
	// Request decode and arbitration
	// ----------------------------------------
	// Enables come from the register, so a clear masks from the next cycle
	always_comb
	begin
		for (int i = 0; i < NSRC; i++)
		begin
			hi_mask[i] = (lvl_t'(req_level_i[2*i +: 2]) == LVL_HI) && ctrl_ff.hi_en; // R13 R16 R17
			med_mask[i] = (lvl_t'(req_level_i[2*i +: 2]) == LVL_MED) && ctrl_ff.med_en; // R14 R16 R17
			lo_mask[i] = (lvl_t'(req_level_i[2*i +: 2]) == LVL_LO) && ctrl_ff.lo_en; // R15 R16 R17
		end
	end

	// Pointer holds a vector, which is index plus one, so zero means static
	assign lo_start = ctrl_ff.rot_en ? ptr_ff : 8'h00; // R7 R9 R10 R11

	lowest_first_pick #(.WIDTH(NSRC)) u_pick_nmi
	(
		.req_i(nmi_req_i),
		.start_i(8'h00),
		.hit_o(nmi_hit),
		.index_o(nmi_idx)
	); // R19 R20

	lowest_first_pick #(.WIDTH(NSRC)) u_pick_hi
	(
		.req_i(hi_mask),
		.start_i(8'h00),
		.hit_o(hi_hit),
		.index_o(hi_idx)
	); // R20

	lowest_first_pick #(.WIDTH(NSRC)) u_pick_med
	(
		.req_i(med_mask),
		.start_i(8'h00),
		.hit_o(med_hit),
		.index_o(med_idx)
	); // R20

	lowest_first_pick #(.WIDTH(NSRC)) u_pick_lo
	(
		.req_i(lo_mask),
		.start_i(lo_start),
		.hit_o(lo_hit),
		.index_o(lo_idx)
	);

	// Offer withdrawn for a cycle after take or return, so flags settle first
	always_comb
	begin
		nxt_offer = '0;
		if (take_i || return_from_interrupt_i)
			nxt_offer = '0;
		else if (nmi_hit && !run_ff.nmi) // R19
			nxt_offer = '{valid: 1'b1, nmi: 1'b1, level: LVL_HI, vector: nmi_idx + 8'h01};
		else if (hi_hit && !run_ff.nmi && !run_ff.hi) // R18
			nxt_offer = '{valid: 1'b1, nmi: 1'b0, level: LVL_HI, vector: hi_idx + 8'h01};
		else if (med_hit && !run_ff.nmi && !run_ff.hi && !run_ff.med) // R18
			nxt_offer = '{valid: 1'b1, nmi: 1'b0, level: LVL_MED, vector: med_idx + 8'h01};
		else if (lo_hit && !run_ff.nmi && !run_ff.hi && !run_ff.med && !run_ff.lo) // R18
			nxt_offer = '{valid: 1'b1, nmi: 1'b0, level: LVL_LO, vector: lo_idx + 8'h01};
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			offer_ff <= '0;
			addr_ff <= RESET_APP_ADDR;
		end
		else
		begin
			offer_ff <= nxt_offer;
			addr_ff <= (ctrl_ff.vec_sel ? BOOT_ADDR : RESET_APP_ADDR) + 16'(nxt_offer.vector) * VEC_STRIDE; // R1 R2
		end
	end

	// ----------------------------------------
	// Running flags
	// ----------------------------------------
	// Return clears the highest flag before the take sets a new one
	always_comb
	begin
		nxt_run = run_ff;
		if (return_from_interrupt_i)
		begin
			if (run_ff.nmi)
				nxt_run.nmi = 1'b0; // R3 R22
			else if (run_ff.hi)
				nxt_run.hi = 1'b0; // R4 R22
			else if (run_ff.med)
				nxt_run.med = 1'b0; // R5 R22
			else
				nxt_run.lo = 1'b0; // R6 R22
		end
		if (take_i && offer_ff.valid)
		begin
			if (offer_ff.nmi)
				nxt_run.nmi = 1'b1; // R3
			else
			begin
				case (offer_ff.level)
					LVL_HI: nxt_run.hi = 1'b1; // R4
					LVL_MED: nxt_run.med = 1'b1; // R5
					LVL_LO: nxt_run.lo = 1'b1; // R6
					default: nxt_run.lo = run_ff.lo;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			run_ff <= '0;
		else
			run_ff <= nxt_run;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	assign wr_ptr = wr_i && addr_i == ADDR_PTR;
	assign wr_ctrl = wr_i && addr_i == ADDR_CTRL;
	assign take_low = take_i && offer_ff.valid && !offer_ff.nmi && offer_ff.level == LVL_LO;

	// Hardware record wins over a software write in the same cycle
	always_comb
	begin
		nxt_ptr = ptr_ff; // R9
		if (take_low && ctrl_ff.rot_en)
			nxt_ptr = offer_ff.vector; // R7
		else if (wr_ptr)
			nxt_ptr = wdata_i; // R8
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ptr_ff <= PTR_RESET;
		else
			ptr_ff <= nxt_ptr;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ctrl_ff <= '0;
		else if (wr_ctrl)
		begin
			ctrl_ff.rot_en <= wdata_i[CTRL_ROT_BIT]; // R10
			ctrl_ff.hi_en <= wdata_i[LVL_HI_BIT]; // R13
			ctrl_ff.med_en <= wdata_i[LVL_MED_BIT]; // R14
			ctrl_ff.lo_en <= wdata_i[LVL_LO_BIT]; // R15
			if (ccp_unlock_i)
				ctrl_ff.vec_sel <= wdata_i[CTRL_SEL_BIT]; // R12
		end
	end

	// Reserved bits and the unused address read zero
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rdata_ff <= 8'h00;
		else if (rd_i)
		begin
			case (addr_i)
				ADDR_STATUS: rdata_ff <= {run_ff.nmi, 4'h0, run_ff.hi, run_ff.med, run_ff.lo}; // R21
				ADDR_PTR: rdata_ff <= ptr_ff; // R8
				ADDR_CTRL: rdata_ff <= {ctrl_ff.rot_en, ctrl_ff.vec_sel, 3'h0,
					ctrl_ff.hi_en, ctrl_ff.med_en, ctrl_ff.lo_en}; // R21
				default: rdata_ff <= 8'h00;
			endcase
		end
		else
			rdata_ff <= 8'h00;
	end

	assign rdata_o = rdata_ff;
	assign irq_offer_o = offer_ff;
	assign irq_addr_o = addr_ff;
	assign reset_addr_o = reset_addr_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence take_low_s;
		take_low && ctrl_ff.rot_en;
	endsequence

	sequence take_nmi_s;
		take_i && offer_ff.valid && offer_ff.nmi;
	endsequence

	sequence ret_only_s;
		return_from_interrupt_i && !take_i;
	endsequence

	chk_nmi_flag_set: assert property (take_nmi_s |=> run_ff.nmi && !offer_ff.valid) // R3
		else $error("non-maskable flag not set on take");
	chk_hi_return: assert property (return_from_interrupt_i && !take_i && !run_ff.nmi && run_ff.hi
		|=> !run_ff.hi && run_ff.med == $past(run_ff.med)) // R4 R22
		else $error("return did not clear only the high flag");
	chk_med_holds: assert property (run_ff.med && !return_from_interrupt_i |=> run_ff.med) // R5 R18
		else $error("medium flag dropped without return");
	chk_low_set: assert property (take_low |=> run_ff.lo) // R6
		else $error("low flag not set on take");
	chk_ptr_record: assert property (take_low_s |=> ptr_ff == $past(offer_ff.vector)) // R7
		else $error("pointer missed the acknowledged low vector");
	chk_ptr_write: assert property (wr_ptr && !(take_low && ctrl_ff.rot_en) |=> ptr_ff == $past(wdata_i)) // R8
		else $error("pointer write lost");
	chk_ptr_kept: assert property (!wr_ptr && !(take_low && ctrl_ff.rot_en) |=> ptr_ff == $past(ptr_ff)) // R9
		else $error("pointer changed with no write or record");
	chk_sel_unlocked: assert property (wr_ctrl && ccp_unlock_i |=> ctrl_ff.vec_sel == $past(wdata_i[CTRL_SEL_BIT])) // R12
		else $error("unlocked table select write lost");
	chk_sel_locked: assert property (wr_ctrl && !ccp_unlock_i |=> $stable(ctrl_ff.vec_sel)) // R12
		else $error("table select changed without unlock");
	chk_hi_gated: assert property (offer_ff.valid && !offer_ff.nmi && offer_ff.level == LVL_HI
		|-> $past(ctrl_ff.hi_en)) // R13 R16
		else $error("high request offered while disabled");
	chk_med_gated: assert property (offer_ff.valid && !offer_ff.nmi && offer_ff.level == LVL_MED // R14 R16
		|-> $past(ctrl_ff.med_en))
		else $error("medium request offered while disabled");
	chk_lo_gated: assert property (offer_ff.valid && !offer_ff.nmi && offer_ff.level == LVL_LO // R15 R16
		|-> $past(ctrl_ff.lo_en))
		else $error("low request offered while disabled");
	chk_addr_base: assert property (offer_ff.valid |-> irq_addr_o == // R1 R2
		($past(ctrl_ff.vec_sel) ? BOOT_ADDR : RESET_APP_ADDR) + 16'(offer_ff.vector) * VEC_STRIDE)
		else $error("vector address off its table");
	chk_reset_hold: assert property (!settle_ff[1] |=> reset_addr_o == RESET_APP_ADDR) // R1
		else $error("reset address moved before fuse settled");
	chk_med_return: assert property (ret_only_s ##0 (!run_ff.nmi && !run_ff.hi && run_ff.med) // R5 R22
		|=> !run_ff.med && run_ff.lo == $past(run_ff.lo))
		else $error("return did not clear only the medium flag");
	chk_low_return: assert property (ret_only_s ##0 (!run_ff.nmi && !run_ff.hi && !run_ff.med && run_ff.lo) // R6 R22
		|=> !run_ff.lo)
		else $error("return did not clear the low flag");
	chk_nmi_first: assert property (nmi_hit && !run_ff.nmi && !take_i && !return_from_interrupt_i // R19 R18
		|=> offer_ff.valid && offer_ff.nmi)
		else $error("non-maskable request not offered first");
	chk_nmi_exclusive: assert property (run_ff.nmi && $past(run_ff.nmi) |-> !offer_ff.valid) // R19
		else $error("offer made during non-maskable handler");
	chk_status_read: assert property (rd_i && addr_i == ADDR_STATUS // R21
		|=> rdata_o[6:3] == 4'h0 ##1 (rdata_o == 8'h00 || $past(rd_i)))
		else $error("status read shows reserved bits");
	chk_ctrl_read: assert property (rd_i && addr_i == ADDR_CTRL |=> rdata_o[5:3] == 3'h0) // R21
		else $error("control read shows reserved bits");

endmodule
`default_nettype wire

// ### tb/cpu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Core side: takes offers, signals returns
// ----------------------------------------
module cpu_core_model
	import mlic_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire offer_t offer_i,
	input wire logic take_en_i,
	input wire logic [3:0] lag_i,
	input wire logic ret_req_i,
	output logic take_o,
	output logic ret_o
);
	logic [3:0] wait_ff;
	// Slow answer: offer must stand lag_i cycles before it is taken
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wait_ff <= 4'h0;
			take_o <= 1'b0;
		end
		else
		begin
			take_o <= take_en_i && offer_i.valid && !take_o && (wait_ff >= lag_i);
			wait_ff <= (take_en_i && offer_i.valid && !take_o) ? wait_ff + 4'h1 : 4'h0;
		end
	end
	// Return pulse copies ret_req_i one cycle later, one pulse for each cycle it is held
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ret_o <= 1'b0;
		else
			ret_o <= ret_req_i;
	end
endmodule
`default_nettype wire

// ### tb/multilevel_interrupt_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
module multilevel_interrupt_unit_tb;
	import mlic_pkg::*;
	localparam logic [15:0] BOOT = 16'h1000;
	logic mclk_i, sys_rst_i, wr_i, rd_i, ccp, fuse, take_en, ret_req, take, ret;
	logic [1:0] addr_i;
	logic [7:0] wdata_i, rdata_o;
	logic [3:0] lag;
	logic [63:0] req;
	logic [31:0] nmi;
	logic [15:0] irq_addr, rst_addr;
	offer_t offer;
	int error_cnt = 0;
	int cmp_count = 0;

	multilevel_interrupt_unit #(.NSRC(32), .BOOT_ADDR(BOOT)) u_multilevel_interrupt_unit (.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.ccp_unlock_i(ccp), .boot_reset_fuse_i(fuse), .req_level_i(req), .nmi_req_i(nmi), .take_i(take),
		.return_from_interrupt_i(ret), .irq_offer_o(offer), .irq_addr_o(irq_addr), .reset_addr_o(rst_addr));
	cpu_core_model u_cpu_core_model (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .offer_i(offer),
		.take_en_i(take_en), .lag_i(lag), .ret_req_i(ret_req), .take_o(take), .ret_o(ret));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task conclude;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task step;
		@(posedge mclk_i);
		#1;
	endtask
	task hang(input string name);
		error_cnt++;
		$display("wrong value %s expected 1 seen 0", name);
		conclude();
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d, input logic u);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		ccp <= u;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		ccp <= 1'b0;
	endtask
	task rchk(input string name, input logic [1:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk(name, {8'h00, e}, {8'h00, rdata_o});
	endtask
	task set_req(input int s, input logic [1:0] l);
		@(posedge mclk_i);
		req[2*s +: 2] <= l;
	endtask
	// Two settle cycles first, so a stale offer is never judged
	task wait_offer(input logic [7:0] v, input logic [15:0] ad);
		int i;
		step();
		step();
		for (i = 0; i < 40 && offer.valid !== 1'b1; i++)
			step();
		if (i == 40)
			hang("offer valid");
		chk("vector", {8'h00, v}, {8'h00, offer.vector});
		chk("vector address", ad, irq_addr);
	endtask
	task no_offer;
		logic s;
		s = 1'b0;
		repeat (10)
		begin
			step();
			s = s | offer.valid;
		end
		chk("offer valid", 16'h0000, {15'h0000, s});
	endtask
	task take_one;
		int i;
		@(posedge mclk_i);
		take_en <= 1'b1;
		for (i = 0; i < 40 && take !== 1'b1; i++)
			step();
		if (i == 40)
			hang("take");
		@(posedge mclk_i);
		take_en <= 1'b0;
	endtask
	task ret_one;
		@(posedge mclk_i);
		ret_req <= 1'b1;
		@(posedge mclk_i);
		ret_req <= 1'b0;
		repeat (3) step();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		chk("reset address", 16'h0000, rst_addr);
		rchk("status", ADDR_STATUS, STATUS_RESET);
		rchk("pointer", ADDR_PTR, PTR_RESET);
		rchk("control", ADDR_CTRL, CTRL_RESET);
		rchk("unmapped", 2'h3, 8'h00);
		wr(ADDR_CTRL, 8'hff, 1'b0);
		rchk("control", ADDR_CTRL, 8'h87);
		wr(ADDR_STATUS, 8'hff, 1'b0);
		rchk("status", ADDR_STATUS, 8'h00);
		wr(ADDR_CTRL, 8'hff, 1'b1);
		rchk("control", ADDR_CTRL, 8'hc7);
		wr(ADDR_CTRL, 8'h00, 1'b1);
		wr(ADDR_PTR, 8'ha5, 1'b0);
		rchk("pointer", ADDR_PTR, 8'ha5);
		wr(ADDR_PTR, 8'h00, 1'b0);
		@(posedge mclk_i);
		fuse <= 1'b0;
		repeat (6) step();
		chk("reset address", BOOT, rst_addr);
		@(posedge mclk_i);
		fuse <= 1'b1;
	endtask
	task t_levels;
		int l;
		for (l = 1; l < 4; l++)
		begin
			set_req(7, l[1:0]);
			wr(ADDR_CTRL, 8'h07 & ~(8'h01 << (l - 1)), 1'b0);
			no_offer();
			wr(ADDR_CTRL, 8'h01 << (l - 1), 1'b0);
			wait_offer(8'h08, 16'h0010);
			chk("level", 16'(l), {14'h0000, offer.level});
			set_req(7, 2'b00);
			wr(ADDR_CTRL, 8'h00, 1'b0);
		end
	endtask
	task t_static;
		set_req(5, 2'b01);
		set_req(2, 2'b01);
		wr(ADDR_CTRL, 8'h01, 1'b0);
		wait_offer(8'h03, 16'h0006);
		wr(ADDR_CTRL, 8'h41, 1'b1);
		wait_offer(8'h03, BOOT + 16'h0006);
		wr(ADDR_CTRL, 8'h01, 1'b0);
		wait_offer(8'h03, BOOT + 16'h0006);
		wr(ADDR_CTRL, 8'h01, 1'b1);
		wait_offer(8'h03, 16'h0006);
		wr(ADDR_CTRL, 8'h00, 1'b0);
		no_offer();
		set_req(5, 2'b00);
		set_req(2, 2'b00);
	endtask
	task t_rotate;
		set_req(1, 2'b01);
		set_req(3, 2'b01);
		wr(ADDR_CTRL, 8'h81, 1'b0);
		wait_offer(8'h02, 16'h0004);
		take_one();
		rchk("pointer", ADDR_PTR, 8'h02);
		rchk("status", ADDR_STATUS, 8'h01);
		ret_one();
		wait_offer(8'h04, 16'h0008);
		take_one();
		ret_one();
		wait_offer(8'h02, 16'h0004);
		wr(ADDR_CTRL, 8'h01, 1'b0);
		rchk("pointer", ADDR_PTR, 8'h04);
		wr(ADDR_PTR, 8'h02, 1'b0);
		wait_offer(8'h02, 16'h0004);
		wr(ADDR_CTRL, 8'h81, 1'b0);
		wait_offer(8'h04, 16'h0008);
		wr(ADDR_PTR, 8'h00, 1'b0);
		wait_offer(8'h02, 16'h0004);
		wr(ADDR_CTRL, 8'h00, 1'b0);
		set_req(1, 2'b00);
		set_req(3, 2'b00);
	endtask
	// Slow core here: offers must stand before being taken
	task t_preempt;
		lag <= 4'h2;
		wr(ADDR_CTRL, 8'h07, 1'b0);
		set_req(4, 2'b01);
		wait_offer(8'h05, 16'h000a);
		take_one();
		set_req(4, 2'b00);
		set_req(6, 2'b10);
		wait_offer(8'h07, 16'h000e);
		take_one();
		set_req(6, 2'b00);
		rchk("status", ADDR_STATUS, 8'h03);
		set_req(8, 2'b11);
		wait_offer(8'h09, 16'h0012);
		take_one();
		set_req(8, 2'b00);
		rchk("status", ADDR_STATUS, 8'h07);
		@(posedge mclk_i);
		nmi <= 32'h0000_0005;
		wait_offer(8'h01, 16'h0002);
		chk("nmi offer", 16'h0001, {15'h0000, offer.nmi});
		take_one();
		rchk("status", ADDR_STATUS, 8'h87);
		set_req(9, 2'b11);
		no_offer();
		set_req(9, 2'b00);
		@(posedge mclk_i);
		nmi <= 32'h0000_0000;
		ret_one();
		rchk("status", ADDR_STATUS, 8'h07);
		ret_one();
		rchk("status", ADDR_STATUS, 8'h03);
		ret_one();
		rchk("status", ADDR_STATUS, 8'h01);
		ret_one();
		rchk("status", ADDR_STATUS, 8'h00);
		wr(ADDR_CTRL, 8'h00, 1'b0);
	endtask

	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial
	begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	initial
	begin
		sys_rst_i = 1'b1;
		{wr_i, rd_i, ccp, take_en, ret_req} = 5'h00;
		fuse = 1'b1;
		lag = 4'h0;
		addr_i = 2'h0;
		wdata_i = 8'h00;
		req = 64'h0;
		nmi = 32'h0;
		repeat (2) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (4) step();
		t_regs();
		t_levels();
		t_static();
		t_rotate();
		t_preempt();
		conclude();
	end
endmodule
`default_nettype wire
